/* File: wwdt_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Clock from RC oscillator, enable forces it
// - Oscillator tick nominally 32 kHz
// - Prescaler divides by 32 or 128
// - Four-bit postscaler, sixteen ratios
// - Chain cleared on reset, power-save entry, exit
// - Chain cleared on clock switch completion
// - Clear instruction clears whole chain
// - Keeps counting in Idle, and in Sleep except under policy 01
// - Time-out in power save wakes core
// - Policy 11 always enabled
// - Policy 10 follows software enable bit
// - Software enable cleared by device reset
// - Time-out flag sticky until software clears
// - Window disable bit zero means windowed
// - Window sizes 25, 37.5, 50, 75 percent
// - Policy 01 active-only, 00 fully off
// - Prescale bit one means 1:128
// - Postscale codes are powers of two
module wwdt_top (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    ce,
    input  wire wwdt_pkg::wwdt_apb_req_t apb_req,
    output var  wwdt_pkg::wwdt_apb_rsp_t apb_rsp,
    input  wire wwdt_pkg::wwdt_evt_t     evt,
    output var  logic                    low_power_rc_osc_on,
    output var  logic                    wd_reset_req,
    output var  logic                    wd_wake_req
);
    import wwdt_pkg::*;

    // Register state
    logic [CFG_W-1:0]   cfg_reg;
    logic [CFG_W-1:0]   cfg_next;
    logic               soft_en_reg;
    logic               soft_en_next;
    logic               timeout_flag_reg;
    logic               timeout_flag_next;
    logic               sleep_flag_reg;
    logic               sleep_flag_next;
    logic               idle_flag_reg;
    logic               idle_flag_next;
    wwdt_pstate_t       pstate_reg;
    wwdt_pstate_t       pstate_next;
    wwdt_apb_rsp_t      rsp_next;

    // Chain interface
    wire  wwdt_cfg_t    cfg = wwdt_cfg_t'(cfg_reg);
    logic               low_power_rc_osc_tick;
    logic               chain_timeout;
    logic               window_open;
    logic [CHAIN_W-1:0] chain_count;

    // Bus decode
    wire  logic        access    = apb_req.psel & apb_req.penable;
    wire  logic        done      = access & apb_rsp.pready;
    wire  logic        answering = access & ~apb_rsp.pready;
    wire  logic [11:0] ofs       = apb_req.paddr[11:0];
    wire  logic        hi_zero   = (apb_req.paddr[31:12] == 20'h00000);
    wire  logic        sel_cfg   = hi_zero & (ofs == OFS_CONFIG);
    wire  logic        sel_rc    = hi_zero & (ofs == OFS_RESET_CTRL);
    wire  logic        sel_st    = hi_zero & (ofs == OFS_STATUS);
    wire  logic        mapped    = sel_cfg | sel_rc | sel_st;
    wire  logic        wr_cfg    = done & apb_req.pwrite & sel_cfg;
    wire  logic        wr_rc     = done & apb_req.pwrite & sel_rc;
    wire  logic [31:0] wdat      = apb_req.pwdata;

    // Power state
    wire  logic in_run   = (pstate_reg == PS_RUN);
    wire  logic in_sleep = (pstate_reg == PS_SLEEP);

    // Enable policy
    wire  logic pol_always = (cfg.wd_enable_policy == POLICY_ALWAYS);
    wire  logic pol_soft   = (cfg.wd_enable_policy == POLICY_SOFT);
    wire  logic pol_active = (cfg.wd_enable_policy == POLICY_ACTIVE);
    wire  logic pol_off    = (cfg.wd_enable_policy == POLICY_OFF);
    wire  logic enabled    = pol_always
                           | (pol_soft & soft_en_reg)
                           | (pol_active & ~in_sleep);

    // Events that act on the chain
    wire  logic enter_save  = in_run & (evt.power_save_sleep | evt.power_save_idle);
    wire  logic wd_wake     = ~in_run & chain_timeout;
    wire  logic leave_save  = ~in_run & (evt.wake_event | chain_timeout);
    wire  logic clr_instr   = in_run & evt.clear_watchdog_instr;
    // The core is expected to clear only inside the window; we police it
    wire  logic early_clear = enabled & clr_instr & ~cfg.wd_window_disable
                            & ~window_open;
    wire  logic run_timeout = in_run & chain_timeout;
    wire  logic chain_clear = evt.device_reset
                            | enter_save | leave_save
                            | evt.clock_switch_done
                            | clr_instr;

    // Write-zero clears a flag; a hardware set in the same cycle still wins
    wire  logic clr_timeout = wr_rc & ~wdat[RC_TIMEOUT_BIT];
    wire  logic clr_sleep   = wr_rc & ~wdat[RC_SLEEP_BIT];
    wire  logic clr_idle    = wr_rc & ~wdat[RC_IDLE_BIT];
    wire  logic set_timeout = chain_timeout | early_clear;

    assign timeout_flag_next = set_timeout | (timeout_flag_reg & ~clr_timeout);
    assign sleep_flag_next   = (in_run & evt.power_save_sleep)
                             | (sleep_flag_reg & ~clr_sleep);
    assign idle_flag_next    = (in_run & evt.power_save_idle & ~evt.power_save_sleep)
                             | (idle_flag_reg & ~clr_idle);

    // Soft enable only has meaning under the software policy
    assign soft_en_next = (evt.device_reset | pol_off | pol_active) ? 1'b0 :
                          (wr_rc & pol_soft) ? wdat[RC_SOFT_EN_BIT] : soft_en_reg;

    assign cfg_next = wr_cfg ? wdat[CFG_W-1:0] : cfg_reg;

    always_comb begin
        pstate_next = pstate_reg;
        unique case (pstate_reg)
            PS_RUN: begin
                if (evt.power_save_sleep) begin
                    pstate_next = PS_SLEEP;
                end else if (evt.power_save_idle) begin
                    pstate_next = PS_IDLE;
                end
            end
            PS_SLEEP, PS_IDLE: begin
                if (evt.wake_event || chain_timeout) begin
                    pstate_next = PS_RUN;
                end
            end
            default: pstate_next = PS_RUN;
        endcase
        if (evt.device_reset) begin
            pstate_next = PS_RUN;
        end
    end

    // Read data
    wire  logic [31:0] rd_cfg = {{(32-CFG_W){1'b0}}, cfg_reg};
    wire  logic [31:0] rd_rc  = {26'h0000000, soft_en_reg, timeout_flag_reg,
                                 sleep_flag_reg, idle_flag_reg, 2'h0};
    wire  logic [31:0] rd_st  = {window_open, ~in_run, enabled,
                                 (29-CHAIN_W)'(0), chain_count};
    wire  logic [31:0] rd_mux = sel_cfg ? rd_cfg :
                                sel_rc  ? rd_rc  :
                                sel_st  ? rd_st  : 32'h00000000;

    // One wait state: pready rises in the second access cycle
    assign rsp_next.pready  = answering;
    assign rsp_next.pslverr = answering & ~mapped;
    assign rsp_next.prdata  = (answering & ~apb_req.pwrite) ? rd_mux : 32'h00000000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_reg          <= CFG_RESET;
            soft_en_reg      <= 1'b0;
            timeout_flag_reg <= 1'b0;
            sleep_flag_reg   <= 1'b0;
            idle_flag_reg    <= 1'b0;
            pstate_reg       <= PS_RUN;
        end else if (ce) begin
            cfg_reg          <= cfg_next;
            soft_en_reg      <= soft_en_next;
            timeout_flag_reg <= timeout_flag_next;
            sleep_flag_reg   <= sleep_flag_next;
            idle_flag_reg    <= idle_flag_next;
            pstate_reg       <= pstate_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            apb_rsp             <= '0;
            low_power_rc_osc_on <= 1'b0;
            wd_reset_req        <= 1'b0;
            wd_wake_req         <= 1'b0;
        end else if (ce) begin
            apb_rsp             <= rsp_next;
            low_power_rc_osc_on <= enabled;
            wd_reset_req        <= run_timeout | early_clear;
            wd_wake_req         <= wd_wake;
        end
    end

    // Oscillator runs only while enabled, so a disabled watchdog burns nothing
    wwdt_low_power_rc_osc_tick u_tick (
        .clk    (clk),
        .resetn (resetn),
        .ce     (ce),
        .osc_on (low_power_rc_osc_on),
        .tick   (low_power_rc_osc_tick)
    );

    wwdt_chain #(
        .CNT_W (CHAIN_W)
    ) u_chain (
        .clk         (clk),
        .resetn      (resetn),
        .ce          (ce),
        .tick        (low_power_rc_osc_tick),
        .run         (enabled),
        .clear       (chain_clear),
        .cfg         (cfg),
        .timeout     (chain_timeout),
        .window_open (window_open),
        .count       (chain_count)
    );

endmodule : wwdt_top
`default_nettype wire

/* File: wwdt_pkg.sv */
`default_nettype none
package wwdt_pkg;

    // Clocking of the counter chain
    localparam int unsigned CLK_FREQ_MHZ    = 100;
    localparam int unsigned LOW_POWER_RC_OSC_FREQ_KHZ   = 32;
    localparam int unsigned LOW_POWER_RC_OSC_DIV_CYCLES = (CLK_FREQ_MHZ * 1000) / LOW_POWER_RC_OSC_FREQ_KHZ;
    localparam int unsigned LOW_POWER_RC_OSC_DIV_W      = 12;

    // Counter chain geometry
    localparam int unsigned CHAIN_W         = 22;
    localparam logic [7:0]  PRE_RATIO_SHORT = 8'h20;
    localparam logic [7:0]  PRE_RATIO_LONG  = 8'h80;

    // Closed part of the period in eighths, per window size code
    localparam logic [2:0]  WIN_CLOSED_00   = 3'h2;
    localparam logic [2:0]  WIN_CLOSED_01   = 3'h4;
    localparam logic [2:0]  WIN_CLOSED_10   = 3'h5;
    localparam logic [2:0]  WIN_CLOSED_11   = 3'h6;

    // Register byte offsets
    localparam logic [11:0] OFS_CONFIG      = 12'h000;
    localparam logic [11:0] OFS_RESET_CTRL  = 12'h004;
    localparam logic [11:0] OFS_STATUS      = 12'h008;

    // Configuration word layout and value after reset
    localparam int unsigned CFG_W           = 10;
    localparam logic [9:0]  CFG_RESET       = 10'h0FF;

    // Reset-control register bits
    localparam int unsigned RC_IDLE_BIT     = 2;
    localparam int unsigned RC_SLEEP_BIT    = 3;
    localparam int unsigned RC_TIMEOUT_BIT  = 4;
    localparam int unsigned RC_SOFT_EN_BIT  = 5;

    // Status register bits
    localparam int unsigned ST_ENABLED_BIT  = 29;
    localparam int unsigned ST_POWSAV_BIT   = 30;
    localparam int unsigned ST_WINOPEN_BIT  = 31;

    // Enable policy codes
    localparam logic [1:0]  POLICY_OFF      = 2'h0;
    localparam logic [1:0]  POLICY_ACTIVE   = 2'h1;
    localparam logic [1:0]  POLICY_SOFT     = 2'h2;
    localparam logic [1:0]  POLICY_ALWAYS   = 2'h3;

    typedef struct packed {
        logic [1:0] wd_window_size;
        logic       wd_window_disable;
        logic [1:0] wd_enable_policy;
        logic       wd_prescale_sel;
        logic [3:0] wd_postscale_sel;
    } wwdt_cfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } wwdt_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } wwdt_apb_rsp_t;

    typedef struct packed {
        logic clear_watchdog_instr;
        logic power_save_sleep;
        logic power_save_idle;
        logic clock_switch_done;
        logic wake_event;
        logic device_reset;
    } wwdt_evt_t;

    typedef enum logic [2:0] {
        PS_RUN   = 3'b001,
        PS_SLEEP = 3'b010,
        PS_IDLE  = 3'b100
    } wwdt_pstate_t;

endpackage : wwdt_pkg
`default_nettype wire

/* File: wwdt_low_power_rc_osc_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module wwdt_low_power_rc_osc_tick (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic osc_on,
    output var  logic tick
);
    import wwdt_pkg::*;

    logic [LOW_POWER_RC_OSC_DIV_W-1:0] div_reg;
    logic [LOW_POWER_RC_OSC_DIV_W-1:0] div_next;
    wire  logic            wrap = (div_reg == LOW_POWER_RC_OSC_DIV_W'(LOW_POWER_RC_OSC_DIV_CYCLES - 1));

    // Oscillator stopped means no ticks and a fresh phase on restart
    assign div_next = (!osc_on || wrap) ? '0 : div_reg + 1'b1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= '0;
            tick    <= 1'b0;
        end else if (ce) begin
            div_reg <= div_next;
            tick    <= osc_on & wrap;
        end
    end
endmodule : wwdt_low_power_rc_osc_tick
`default_nettype wire

/* File: wwdt_chain.sv */
`timescale 1ns/1ps
`default_nettype none
module wwdt_chain #(
    parameter int unsigned CNT_W = wwdt_pkg::CHAIN_W
) (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                ce,
    input  wire logic                tick,
    input  wire logic                run,
    input  wire logic                clear,
    input  wire wwdt_pkg::wwdt_cfg_t cfg,
    output var  logic                timeout,
    output var  logic                window_open,
    output var  logic [CNT_W-1:0]    count
);
    import wwdt_pkg::*;

    function automatic logic [2:0] closed_eighths(input logic [1:0] code);
        unique case (code)
            2'h0: closed_eighths = WIN_CLOSED_00;
            2'h1: closed_eighths = WIN_CLOSED_01;
            2'h2: closed_eighths = WIN_CLOSED_10;
            default: closed_eighths = WIN_CLOSED_11;
        endcase
    endfunction : closed_eighths

    // Low bits act as the prescaler, high bits as the postscaler; one adder
    // keeps both cleared together
    wire logic [CNT_W:0]   base      = cfg.wd_prescale_sel ?
                                       (CNT_W+1)'(PRE_RATIO_LONG) :
                                       (CNT_W+1)'(PRE_RATIO_SHORT);
    wire logic [CNT_W:0]   period    = base << cfg.wd_postscale_sel;
    wire logic [CNT_W-1:0] last      = CNT_W'(period - 1'b1);
    wire logic [CNT_W:0]   threshold = (CNT_W+1)'((period >> 3) *
                                       (CNT_W+1)'(closed_eighths(cfg.wd_window_size)));

    assign timeout     = run & tick & (count == last);
    assign window_open = ({1'b0, count} >= threshold);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (ce) begin
            if (clear || timeout) begin
                count <= '0;
            end else if (run && tick) begin
                count <= count + 1'b1;
            end
        end
    end
endmodule : wwdt_chain
`default_nettype wire

/* File: wwdt_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module wwdt_monitor (
    input wire logic                    clk,
    input wire logic                    resetn,
    input wire logic                    ce,
    input wire wwdt_pkg::wwdt_apb_req_t apb_req,
    input wire wwdt_pkg::wwdt_apb_rsp_t apb_rsp,
    input wire wwdt_pkg::wwdt_evt_t     evt,
    input wire logic                    low_power_rc_osc_on,
    input wire logic                    wd_reset_req,
    input wire logic                    wd_wake_req
);
    import wwdt_pkg::*;
    // Policy and power state are rebuilt from the ports, since internals are unseen
    logic [1:0] pol_reg;
    logic       ps_reg;
    wire        wr_done = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    wire        cfg_wr  = wr_done && apb_req.paddr == {20'h0, OFS_CONFIG};
    wire        soft_wr = wr_done && apb_req.paddr == {20'h0, OFS_RESET_CTRL} && apb_req.pwdata[5];
    wire        mapped  = apb_req.paddr inside {{20'h0, OFS_CONFIG}, {20'h0, OFS_RESET_CTRL},
                                                {20'h0, OFS_STATUS}};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pol_reg <= POLICY_ALWAYS;
            ps_reg  <= 1'b0;
        end else if (ce) begin
            if (cfg_wr) begin
                pol_reg <= apb_req.pwdata[6:5];
            end
            if (wd_wake_req || evt.wake_event || evt.device_reset) begin
                ps_reg <= 1'b0;
            end else if (evt.power_save_sleep || evt.power_save_idle) begin
                ps_reg <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn || !ce);

    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence s_access;
        apb_req.psel && apb_req.penable;
    endsequence

    property p_apb_wait;
        s_setup ##1 s_access |-> !apb_rsp.pready ##1 apb_rsp.pready;
    endproperty
    property p_slverr;
        apb_rsp.pready |-> apb_rsp.pslverr == !mapped;
    endproperty
    property p_always_on;
        pol_reg == POLICY_ALWAYS |=> low_power_rc_osc_on;
    endproperty
    property p_off;
        pol_reg == POLICY_OFF |=> !low_power_rc_osc_on;
    endproperty
    property p_soft_on;
        pol_reg == POLICY_SOFT && soft_wr |-> ##2 low_power_rc_osc_on;
    endproperty
    property p_soft_reset;
        (pol_reg == POLICY_SOFT && evt.device_reset) ##1 !soft_wr |=> !low_power_rc_osc_on;
    endproperty
    property p_req_enabled;
        wd_reset_req || wd_wake_req |-> $past(low_power_rc_osc_on);
    endproperty
    property p_wake_ps;
        wd_wake_req |-> ps_reg && !wd_reset_req;
    endproperty
    property p_reset_run;
        wd_reset_req |-> !ps_reg;
    endproperty
    property p_pulse;
        $rose(wd_wake_req) |=> $fell(wd_wake_req);
    endproperty

    a_apb_wait : assert property (p_apb_wait)
        else $error("Bus answer not after one wait state");
    a_slverr : assert property (p_slverr)
        else $error("Error response does not match address map");
    a_always_on : assert property (p_always_on)
        else $error("Oscillator off under always-on policy");
    a_off : assert property (p_off)
        else $error("Oscillator on under off policy");
    a_soft_on : assert property (p_soft_on)
        else $error("Soft enable did not start watchdog");
    a_soft_reset : assert property (p_soft_reset)
        else $error("Device reset left soft enable set");
    a_req_enabled : assert property (p_req_enabled)
        else $error("Request while watchdog disabled");
    a_wake_ps : assert property (p_wake_ps)
        else $error("Wake request outside power save");
    a_reset_run : assert property (p_reset_run)
        else $error("Reset request during power save");
    a_pulse : assert property (p_pulse)
        else $error("Wake request longer than one cycle");
endmodule : wwdt_monitor
`default_nettype wire

/* File: wwdt_testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, (ex), (got)); end end
module testbench;
    import wwdt_pkg::*;
    localparam logic [31:0] A_CFG  = {20'h0, OFS_CONFIG};
    localparam logic [31:0] A_RC   = {20'h0, OFS_RESET_CTRL};
    localparam logic [31:0] A_ST   = {20'h0, OFS_STATUS};
    localparam wwdt_evt_t   EV_CLR = 6'h20;
    localparam wwdt_evt_t   EV_SLP = 6'h10;
    localparam wwdt_evt_t   EV_IDL = 6'h08;
    localparam wwdt_evt_t   EV_SW  = 6'h04;
    localparam wwdt_evt_t   EV_WK  = 6'h02;
    localparam wwdt_evt_t   EV_RST = 6'h01;
    logic          clk;
    logic          resetn;
    logic          ce;
    wwdt_apb_req_t req;
    wwdt_apb_rsp_t rsp;
    wwdt_evt_t     evt;
    logic          osc_on;
    logic          rst_req;
    logic          wake_req;
    logic [31:0]   q;
    logic          e;
    int            err_count = 0;
    int            tests_run = 0;

    wwdt_top i_dut (
        .clk                 (clk),
        .resetn              (resetn),
        .ce                  (ce),
        .apb_req             (req),
        .apb_rsp             (rsp),
        .evt                 (evt),
        .low_power_rc_osc_on (osc_on),
        .wd_reset_req        (rst_req),
        .wd_wake_req         (wake_req)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task give_verdict;
        $display("Errors %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        req.psel   <= 1'b1;
        req.pwrite <= wr;
        req.paddr  <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 20) begin
            err_count++;
            give_verdict();
        end
    endtask : apb

    task automatic pulse(input wwdt_evt_t v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= '0;
    endtask : pulse

    task t_bus;
        apb(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
        `CHK("unmapped write err", 1'b1, e)
        apb(1'b0, 32'h0000_000C, 32'h0);
        `CHK("unmapped read", 33'h1_0000_0000, {e, q})
    endtask : t_bus

    task t_reset;
        apb(1'b0, A_CFG, 32'h0);
        `CHK("config reset", {22'h0, CFG_RESET}, q)
        apb(1'b0, A_RC, 32'h0);
        `CHK("reset ctrl reset", 32'h0, q)
        `CHK("osc on", 1'b1, osc_on)
    endtask : t_reset

    task t_policy;
        apb(1'b1, A_CFG, 32'h0000_0080);
        apb(1'b1, A_RC, 32'h0000_0020);
        apb(1'b0, A_RC, 32'h0);
        `CHK("off soft bit", 32'h0, q)
        `CHK("off osc", 1'b0, osc_on)
        apb(1'b1, A_CFG, 32'h0000_00C0);
        apb(1'b1, A_RC, 32'h0000_0020);
        apb(1'b0, A_RC, 32'h0);
        `CHK("soft bit", 32'h0000_0020, q)
        `CHK("soft osc", 1'b1, osc_on)
        pulse(EV_RST);
        apb(1'b0, A_RC, 32'h0);
        `CHK("soft bit after reset", 32'h0, q)
        `CHK("osc after reset", 1'b0, osc_on)
        apb(1'b1, A_CFG, 32'h0000_00A0);
        repeat (2) @(posedge clk);
        `CHK("active osc", 1'b1, osc_on)
        pulse(EV_SLP);
        repeat (2) @(posedge clk);
        `CHK("active osc in sleep", 1'b0, osc_on)
        pulse(EV_WK);
        repeat (2) @(posedge clk);
        `CHK("active osc after wake", 1'b1, osc_on)
        // Active-only policy stops in Sleep but keeps running in Idle
        pulse(EV_IDL);
        repeat (2) @(posedge clk);
        `CHK("active osc in idle", 1'b1, osc_on)
        pulse(EV_WK);
        apb(1'b0, A_RC, 32'h0);
        `CHK("sleep and idle flags", 32'h0000_000C, q)
        apb(1'b1, A_RC, 32'h0);
    endtask : t_policy

    task automatic t_clear;
        int n;
        // Ticks come every 3125 cycles, so 3200 cycles always span one
        apb(1'b1, A_CFG, 32'h0000_00E0);
        repeat (3200) @(posedge clk);
        apb(1'b0, A_ST, 32'h0);
        `CHK("count runs", 1'b1, q[21:0] != 22'h0)
        pulse(EV_CLR);
        apb(1'b0, A_ST, 32'h0);
        `CHK("count after clear", 22'h0, q[21:0])
        repeat (3200) @(posedge clk);
        pulse(EV_SW);
        apb(1'b0, A_ST, 32'h0);
        `CHK("count after switch", 22'h0, q[21:0])
        apb(1'b0, A_RC, 32'h0);
        `CHK("no flag unwindowed", 32'h0, q)
        apb(1'b1, A_CFG, 32'h0000_0060);
        repeat (3200) @(posedge clk);
        apb(1'b0, A_ST, 32'h0);
        `CHK("window shut", 1'b0, q[31])
        pulse(EV_CLR);
        n = 0;
        while (rst_req !== 1'b1 && n < 3) begin
            @(posedge clk);
            n++;
        end
        `CHK("early clear reset", 1'b1, rst_req)
        apb(1'b1, A_RC, 32'h0000_0010);
        apb(1'b0, A_RC, 32'h0);
        `CHK("flag sticky", 32'h0000_0010, q)
        apb(1'b1, A_RC, 32'h0);
        apb(1'b0, A_RC, 32'h0);
        `CHK("flag cleared", 32'h0, q)
    endtask : t_clear

    task automatic t_sleep;
        int n;
        apb(1'b1, A_CFG, 32'h0000_00E0);
        repeat (3200) @(posedge clk);
        pulse(EV_SLP);
        apb(1'b0, A_ST, 32'h0);
        `CHK("entry clears", 22'h0, q[21:0])
        `CHK("in power save", 1'b1, q[30])
        n = 0;
        while (wake_req !== 1'b1 && n < 110000) begin
            @(posedge clk);
            n++;
        end
        `CHK("wake seen", 1'b1, wake_req)
        // Prescale 32, postscale 1:1: 32 ticks of 3125 cycles
        `CHK("wake time", 1'b1, n > 96000 && n < 100010)
        apb(1'b0, A_RC, 32'h0);
        `CHK("flags after wake", 32'h0000_0018, q)
        apb(1'b0, A_ST, 32'h0);
        `CHK("running after wake", 1'b0, q[30])
    endtask : t_sleep

    initial begin
        ce     = 1'b1;
        resetn = 1'b0;
        req    = '0;
        evt    = '0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        t_bus;
        t_reset;
        t_policy;
        t_clear;
        t_sleep;
        give_verdict;
    end
endmodule : testbench

bind wwdt_top wwdt_monitor i_mon (
    .clk                 (clk),
    .resetn              (resetn),
    .ce                  (ce),
    .apb_req             (apb_req),
    .apb_rsp             (apb_rsp),
    .evt                 (evt),
    .low_power_rc_osc_on (low_power_rc_osc_on),
    .wd_reset_req        (wd_reset_req),
    .wd_wake_req         (wd_wake_req)
);
`default_nettype wire
